// *** hw/hbc_core.sv ***
// Host bus control pins, config load and Avalon register slave
// Operation
// R1: Sync direction line high write, low read
// R2: Claim access only while qualifier low
// R3: Async write strobe low accepts write
// R4: Latch address and qualifier on strobe rise
// R5: No ROM: data-in level picks width
// R6: Config ROM serial clock period 4 us
// R7: Sample ROM data in, shift commands out
// R8: Sleep input low powers chip down
// R9: Async read strobe low presents read data
// R10: ROM used only when present strap high
// R11: Local select low on qualifier and match
// R12: Host drives byte enables low per lane
// R13: Latched address held until next strobe rise
//
// Register access over Avalon-MM and the register offsets were left to the implementer.
`include "hbc_params.svh"
module hbc_core
    import hbc_pkg::*;
#(
    parameter int WORDS = 4
)(
    input wire logic CORE_CLK,
    input wire logic RSTN,
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic SYNC_WRITE_READ_SEL,
    input wire logic ADDR_QUALIFIER_N,
    input wire logic ASYNC_WRITE_STROBE_N,
    input wire logic ASYNC_READ_STROBE_N,
    input wire logic ADDR_LATCH_STROBE_N,
    input wire logic [15:1] ADDR,
    input wire logic [3:0] BYTE_LANE_EN_N,
    input wire logic CHIP_SLEEP_N,
    input wire logic CFG_ROM_PRESENT_STRAP,
    input wire logic CFG_ROM_SERIAL_IN,
    output logic CFG_ROM_SERIAL_OUT,
    output logic CFG_ROM_SERIAL_CLK,
    output logic CFG_ROM_SELECT,
    output logic LOCAL_SELECT_N,
    output logic ACCESS_WRITE,
    output logic ACCESS_READ,
    output logic [15:1] ACCESS_ADDR,
    output logic [3:0] ACCESS_BE,
    output logic [1:0] BUS_WIDTH,
    output logic CFG_DONE,
    output logic SLEEP_STATE
);
    hbc_rom_if #(.WORDS(WORDS)) rom ();

    logic [3:0] ctrl, next_ctrl;
    logic [15:0] base, next_base;
    logic next_wait, start, next_start;
    logic [31:0] next_rdata;
    logic addr_latch_strobe_n_q, lat_aen, next_lat_aen;
    logic [15:1] lat_addr, next_lat_addr;
    logic strap_done, present, pin_w16;
    logic next_strap_done, next_present, next_pin_w16;
    hbc_width_t width, next_width;
    logic next_sel_n, next_wr, next_rd, next_done;
    logic [15:1] eff_addr;
    logic eff_aen, claim, addr_latch_strobe_n_rise, bus_take, awake;

    function automatic logic addr_match(input logic [15:1] a,
        input logic [15:0] b);
        addr_match = (a[15:4] == b[15:4]);
    endfunction

    assign awake = CHIP_SLEEP_N; // see R8
    assign addr_latch_strobe_n_rise = ADDR_LATCH_STROBE_N && !addr_latch_strobe_n_q; // see R4
    assign eff_addr = ctrl[`HBC_CTRL_LATCH] ? lat_addr : ADDR; // see R13
    assign eff_aen = ctrl[`HBC_CTRL_LATCH] ? lat_aen : ADDR_QUALIFIER_N;
    assign claim = awake && !eff_aen && addr_match(eff_addr, base); // see R2
    assign bus_take = (AVS_READ || AVS_WRITE) && !AVS_WAITREQUEST;
    assign rom.start = start;
    assign rom.sleep = !awake; // see R8
    assign rom.rd_idx = $clog2(WORDS)'(AVS_ADDRESS[3:2]);

    hbc_rom_loader #(.WORDS(WORDS)) u_loader (
        .clk(CORE_CLK),
        .rst_n(RSTN),
        .rom(rom.loader),
        .sk(CFG_ROM_SERIAL_CLK),
        .cs(CFG_ROM_SELECT),
        .dout(CFG_ROM_SERIAL_OUT),
        .din(CFG_ROM_SERIAL_IN)
    );

    // Avalon slave and registers
    always_comb
    begin
        next_wait = !((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST);
        next_ctrl = ctrl;
        next_base = base;
        next_start = !strap_done && CFG_ROM_PRESENT_STRAP; // see R10
        next_ctrl[`HBC_CTRL_RELOAD] = 1'b0;
        if (bus_take && AVS_WRITE)
        begin
            if (AVS_ADDRESS == `HBC_CTRL_OFS && AVS_BYTEENABLE[0])
            begin
                next_ctrl = AVS_WRITEDATA[3:0];
                next_start = AVS_WRITEDATA[`HBC_CTRL_RELOAD] && present;
            end
            if (AVS_ADDRESS == `HBC_BASE_OFS)
            begin
                if (AVS_BYTEENABLE[0])
                    next_base[7:0] = AVS_WRITEDATA[7:0];
                if (AVS_BYTEENABLE[1])
                    next_base[15:8] = AVS_WRITEDATA[15:8];
            end
        end
        next_rdata = AVS_READDATA;
        if (AVS_READ && AVS_WAITREQUEST)
        begin
            next_rdata = 32'h0000_0000;
            if (AVS_ADDRESS == `HBC_CTRL_OFS)
                next_rdata[3:0] = ctrl;
            else if (AVS_ADDRESS == `HBC_STAT_OFS)
                next_rdata[6:0] = {lat_aen, present, width, !awake,
                    rom.busy, CFG_DONE};
            else if (AVS_ADDRESS == `HBC_BASE_OFS)
                next_rdata[15:0] = base;
            else if (AVS_ADDRESS == `HBC_LATCH_OFS)
                next_rdata[15:1] = lat_addr;
            else if (AVS_ADDRESS[7:4] == `HBC_CFG_OFS_HI
                && AVS_ADDRESS[1:0] == 2'h0
                && 32'(AVS_ADDRESS[3:2]) < WORDS)
                next_rdata[15:0] = rom.rd_data;
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RSTN)
        begin
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA <= 32'h0000_0000;
            ctrl <= `HBC_CTRL_RST;
            base <= `HBC_BASE_RST;
            start <= 1'b0;
        end
        else
        begin
            AVS_WAITREQUEST <= next_wait;
            AVS_READDATA <= next_rdata;
            ctrl <= next_ctrl;
            base <= next_base;
            start <= next_start;
        end
    end

    // Strap capture, width selection and host pin decode
    always_comb
    begin
        next_strap_done = 1'b1;
        next_present = strap_done ? present : CFG_ROM_PRESENT_STRAP;
        next_pin_w16 = strap_done ? pin_w16 : CFG_ROM_SERIAL_IN; // see R5
        next_width = width;
        if (ctrl[`HBC_CTRL_FORCE32])
            next_width = HBC_W32; // see R5
        else if (strap_done && !present)
            next_width = pin_w16 ? HBC_W16 : HBC_W8; // see R5
        else if (strap_done && rom.done)
            next_width = rom.cfg0[`HBC_CFG_W16_BIT] ? HBC_W16 : HBC_W8;
        next_done = strap_done && (present ? rom.done : 1'b1);
        next_lat_addr = addr_latch_strobe_n_rise ? ADDR : lat_addr; // see R4
        next_lat_aen = addr_latch_strobe_n_rise ? ADDR_QUALIFIER_N : lat_aen;
        next_sel_n = !claim; // see R11
        if (ctrl[`HBC_CTRL_SYNC])
        begin
            next_wr = claim && SYNC_WRITE_READ_SEL; // see R1
            next_rd = claim && !SYNC_WRITE_READ_SEL;
        end
        else
        begin
            next_wr = claim && !ASYNC_WRITE_STROBE_N; // see R3
            next_rd = claim && !ASYNC_READ_STROBE_N; // see R9
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RSTN)
        begin
            strap_done <= 1'b0;
            present <= 1'b0;
            pin_w16 <= 1'b0;
            width <= HBC_W8;
            addr_latch_strobe_n_q <= 1'b1;
            lat_addr <= 15'h0000;
            lat_aen <= 1'b1;
            LOCAL_SELECT_N <= 1'b1;
            ACCESS_WRITE <= 1'b0;
            ACCESS_READ <= 1'b0;
            ACCESS_ADDR <= 15'h0000;
            ACCESS_BE <= 4'h0;
            BUS_WIDTH <= 2'h0;
            CFG_DONE <= 1'b0;
            SLEEP_STATE <= 1'b0;
        end
        else
        begin
            strap_done <= next_strap_done;
            present <= next_present;
            pin_w16 <= next_pin_w16;
            width <= next_width;
            addr_latch_strobe_n_q <= ADDR_LATCH_STROBE_N;
            lat_addr <= next_lat_addr;
            lat_aen <= next_lat_aen;
            LOCAL_SELECT_N <= next_sel_n;
            ACCESS_WRITE <= next_wr;
            ACCESS_READ <= next_rd;
            ACCESS_ADDR <= eff_addr;
            ACCESS_BE <= claim ? ~BYTE_LANE_EN_N : 4'h0; // see R12
            BUS_WIDTH <= width;
            CFG_DONE <= next_done;
            SLEEP_STATE <= !awake; // see R8
        end
    end

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);

    sequence s_strobe_rise;
        !ADDR_LATCH_STROBE_N ##1 ADDR_LATCH_STROBE_N;
    endsequence

    a_local_select: assert property ( // see R11
        awake && !ctrl[`HBC_CTRL_LATCH] && !ADDR_QUALIFIER_N
            && ADDR[15:4] == base[15:4] |=> !LOCAL_SELECT_N)
    else $error("local select missing on match");
    a_qualifier_gate: assert property ( // see R2
        !ctrl[`HBC_CTRL_LATCH] && ADDR_QUALIFIER_N
            |=> LOCAL_SELECT_N && !ACCESS_WRITE && !ACCESS_READ)
    else $error("access claimed with qualifier high");
    a_sync_direction: assert property ( // see R1
        ctrl[`HBC_CTRL_SYNC] && !LOCAL_SELECT_N
            |-> ACCESS_WRITE == $past(SYNC_WRITE_READ_SEL)
                && ACCESS_READ == !$past(SYNC_WRITE_READ_SEL))
    else $error("sync direction not followed");
    a_async_write: assert property ( // see R3
        !ctrl[`HBC_CTRL_SYNC] && claim && !ASYNC_WRITE_STROBE_N
            |=> ACCESS_WRITE)
    else $error("async write strobe not accepted");
    a_async_read: assert property ( // see R9
        !ctrl[`HBC_CTRL_SYNC] && claim
            |=> ACCESS_READ == !$past(ASYNC_READ_STROBE_N))
    else $error("async read strobe not followed");
    a_latch_capture: assert property ( // see R4
        s_strobe_rise |=> lat_addr == $past(ADDR)
            && lat_aen == $past(ADDR_QUALIFIER_N))
    else $error("address not latched on strobe rise");
    a_latch_hold: assert property ( // see R13
        !addr_latch_strobe_n_rise |=> $stable(lat_addr) && $stable(lat_aen))
    else $error("latched address changed between strobes");
    a_sleep_blocks: assert property ( // see R8
        !CHIP_SLEEP_N |=> SLEEP_STATE && LOCAL_SELECT_N && !ACCESS_WRITE
            && !CFG_ROM_SELECT)
    else $error("activity during power down");
    a_width_strap: assert property ( // see R5
        strap_done && !present && !ctrl[`HBC_CTRL_FORCE32]
            |=> width == ($past(pin_w16) ? HBC_W16 : HBC_W8))
    else $error("bus width not from data-in strap");
    a_rom_absent: assert property ( // see R10
        strap_done && !present && !rom.busy |-> !start)
    else $error("ROM load started without strap");
endmodule

// *** hw/hbc_params.svh ***
// Constants for the host bus control and config load block
`ifndef HBC_PARAMS_SVH
`define HBC_PARAMS_SVH
`define HBC_CTRL_OFS 8'h00
`define HBC_STAT_OFS 8'h04
`define HBC_BASE_OFS 8'h08
`define HBC_LATCH_OFS 8'h0C
`define HBC_CFG_OFS_HI 4'h1
`define HBC_CTRL_RST 4'h0
`define HBC_BASE_RST 16'h0300
`define HBC_CTRL_SYNC 0
`define HBC_CTRL_LATCH 1
`define HBC_CTRL_FORCE32 2
`define HBC_CTRL_RELOAD 3
`define HBC_CFG_W16_BIT 0
`define HBC_CLK_PERIOD_NS 25
`define HBC_SK_PERIOD_NS 4000
`define HBC_SK_HALF ((`HBC_SK_PERIOD_NS / `HBC_CLK_PERIOD_NS) / 2)
`define HBC_ROM_READ_OP 3'h6
`define HBC_ROM_DATA_BITS 16
`endif

// *** hw/hbc_pkg.sv ***
// Types for the host bus control and config load block
package hbc_pkg;
    typedef enum logic [1:0] {HBC_W8, HBC_W16, HBC_W32} hbc_width_t;
    typedef enum logic [1:0] {LD_IDLE, LD_CMD, LD_DATA, LD_END} hbc_ld_t;
endpackage

// *** hw/hbc_rom_if.sv ***
// Link between the bus control core and the config ROM loader
interface hbc_rom_if #(parameter int WORDS = 4);
    logic start;
    logic sleep;
    logic busy;
    logic done;
    logic [$clog2(WORDS)-1:0] rd_idx;
    logic [15:0] rd_data;
    logic [15:0] cfg0;
    modport loader (input start, sleep, rd_idx, output busy, done, rd_data,
        cfg0);
    modport ctrl (output start, sleep, rd_idx, input busy, done, rd_data,
        cfg0);
endinterface

// *** hw/hbc_rom_loader.sv ***
// Serial config ROM reader with divided serial clock
`include "hbc_params.svh"
module hbc_rom_loader
    import hbc_pkg::*;
#(
    parameter int WORDS = 4,
    parameter int AW = 6
)(
    input wire logic clk,
    input wire logic rst_n,
    hbc_rom_if.loader rom,
    output logic sk,
    output logic cs,
    output logic dout,
    input wire logic din
);
    localparam int CW = 3 + AW;
    localparam logic [7:0] HALF = 8'(`HBC_SK_HALF);
    hbc_ld_t state, next_state;
    logic [7:0] div, next_div;
    logic next_sk, next_cs, next_dout, mem_we;
    logic [4:0] bitcnt, next_bitcnt;
    logic [$clog2(WORDS)-1:0] widx, next_widx;
    logic [CW-1:0] cmd, next_cmd;
    logic [15:0] shreg, next_shreg;
    logic [15:0] mem [WORDS];
    logic tick;

    assign tick = (div == HALF - 8'h01);
    assign rom.rd_data = mem[rom.rd_idx];
    assign rom.cfg0 = mem[0];
    assign rom.busy = (state != LD_IDLE) && (state != LD_END);
    assign rom.done = (state == LD_END);

    always_comb
    begin
        next_state = state;
        next_div = (state == LD_IDLE || state == LD_END || tick) ? 8'h00
            : div + 8'h01; // see R6
        next_sk = sk;
        next_cs = cs;
        next_dout = dout;
        next_bitcnt = bitcnt;
        next_widx = widx;
        next_cmd = cmd;
        next_shreg = shreg;
        mem_we = 1'b0;
        case (state)
            LD_IDLE, LD_END:
            begin
                if (rom.start && !rom.sleep)
                begin
                    next_state = LD_CMD;
                    next_cs = 1'b1;
                    next_sk = 1'b0;
                    next_widx = '0;
                    next_cmd = {`HBC_ROM_READ_OP, {AW{1'b0}}};
                    next_dout = 1'b1;
                    next_bitcnt = 5'(CW - 1);
                end
            end
            LD_CMD:
            begin
                if (tick)
                begin
                    next_sk = !sk; // see R6
                    if (sk)
                    begin
                        next_cmd = {cmd[CW-2:0], 1'b0};
                        next_dout = cmd[CW-2]; // see R7
                        if (bitcnt == 5'h00)
                        begin
                            next_state = LD_DATA;
                            next_dout = 1'b0;
                            next_bitcnt = 5'(`HBC_ROM_DATA_BITS - 1);
                        end
                        else
                            next_bitcnt = bitcnt - 5'h01;
                    end
                end
            end
            LD_DATA:
            begin
                if (tick)
                begin
                    next_sk = !sk;
                    if (!sk)
                        next_shreg = {shreg[14:0], din}; // see R7
                    else if (bitcnt == 5'h00)
                    begin
                        mem_we = 1'b1;
                        if (widx == $clog2(WORDS)'(WORDS - 1))
                        begin
                            next_state = LD_END;
                            next_cs = 1'b0;
                        end
                        else
                        begin
                            next_state = LD_CMD;
                            next_widx = widx + 1'b1;
                            next_cmd = {`HBC_ROM_READ_OP, AW'(widx + 1'b1)};
                            next_dout = 1'b1;
                            next_bitcnt = 5'(CW - 1);
                        end
                    end
                    else
                        next_bitcnt = bitcnt - 5'h01;
                end
            end
            default:
                next_state = LD_IDLE;
        endcase
        if (rom.sleep)
        begin
            next_state = LD_IDLE;
            next_cs = 1'b0;
            next_sk = 1'b0;
            next_dout = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state <= LD_IDLE;
            div <= 8'h00;
            sk <= 1'b0;
            cs <= 1'b0;
            dout <= 1'b0;
            bitcnt <= 5'h00;
            widx <= '0;
            cmd <= '0;
            shreg <= 16'h0000;
        end
        else
        begin
            state <= next_state;
            div <= next_div;
            sk <= next_sk;
            cs <= next_cs;
            dout <= next_dout;
            bitcnt <= next_bitcnt;
            widx <= next_widx;
            cmd <= next_cmd;
            shreg <= next_shreg;
        end
    end

    always_ff @(posedge clk)
    begin
        if (mem_we)
            mem[widx] <= shreg;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_sk_half_period: assert property ( // see R6
        (sk != $past(sk)) && !$past(rom.sleep) && $past(cs)
            |-> $past(div) == HALF - 8'h01)
    else $error("serial clock edge off the divider");
    a_dout_on_fall: assert property ( // see R7
        (dout != $past(dout)) && cs && $past(cs) |-> !sk && $past(sk))
    else $error("serial data changed outside a falling clock edge");
    a_sample_rise: assert property ( // see R7
        state == LD_DATA && tick && !sk
            |=> sk && shreg[0] == $past(din))
    else $error("serial input not sampled at rising clock");
endmodule

// *** sim/hbc_rom_model.sv ***
// Serial config ROM model on the loader's far side
module hbc_rom_model #(
    parameter int WORDS = 4,
    parameter logic [15:0] W0 = 16'h5A31
)(
    input wire logic sk,
    input wire logic cs,
    input wire logic di,
    output logic dout,
    output logic cmd_err
);
    timeunit 1ns;
    timeprecision 1ps;
    int bitc = 0;
    int k;
    logic [8:0] cmd = 9'h000;
    logic [15:0] w;
    initial dout = 1'b0;
    initial cmd_err = 1'b0;
    // Command bits taken on clock rise
    always @(posedge sk or negedge cs)
    begin
        if (!cs)
            bitc = 0;
        else
        begin
            // Next command follows each word with select held
            if (bitc == 25)
                bitc = 0;
            if (bitc < 9)
                cmd = {cmd[7:0], di};
            bitc++;
            if (bitc == 9 && cmd[8:6] !== 3'b110)
                cmd_err = 1'b1;
        end
    end
    // Data bits shifted out on clock fall, line pulled down when idle
    always @(negedge sk or negedge cs)
    begin
        if (!cs)
            dout = 1'b0;
        else if (bitc >= 9)
        begin
            k = (bitc - 9) / 16 + int'(cmd[5:0]);
            w = (k == 0) ? W0 : 16'hC3A0 + 16'(k);
            if (k < WORDS)
                dout = w[15 - (bitc - 9) % 16];
            else
                dout = ~dout;
        end
    end
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench for the host bus control block
module tb_top import hbc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WORDS = 4;
    localparam logic [15:0] W0 = 16'h5A31;
    logic core_clk = 1'b0, rstn = 1'b0, av_rd = 1'b0, av_wr = 1'b0;
    logic [7:0] av_addr = 8'h00;
    logic [31:0] av_wdata = 32'h0, av_rdata, rd;
    logic [3:0] av_be = 4'h0, be_n = 4'hF, acc_be;
    logic sync_write_read_sel = 1'b0, qual_n = 1'b1, wr_n = 1'b1, rd_n = 1'b1;
    logic als_n = 1'b1, sleep_n = 1'b1, strap = 1'b0, din_lvl = 1'b0;
    logic [15:1] addr = 15'h0, acc_addr;
    logic av_wait, rom_out, rom_sk, rom_cs, lsel_n, acc_wr, acc_rd;
    logic cfg_done, asleep, rom_do, cmd_err, rom_in;
    logic [1:0] bus_w;
    int fail_count = 0;
    int cmp_count = 0;
    always #12.5 core_clk = ~core_clk;
    assign rom_in = strap ? rom_do : din_lvl;
    hbc_core #(.WORDS(WORDS)) hbc_core_inst (.CORE_CLK(core_clk),
        .RSTN(rstn), .AVS_ADDRESS(av_addr), .AVS_READ(av_rd),
        .AVS_WRITE(av_wr), .AVS_WRITEDATA(av_wdata),
        .AVS_BYTEENABLE(av_be), .AVS_READDATA(av_rdata),
        .AVS_WAITREQUEST(av_wait), .SYNC_WRITE_READ_SEL(sync_write_read_sel),
        .ADDR_QUALIFIER_N(qual_n), .ASYNC_WRITE_STROBE_N(wr_n),
        .ASYNC_READ_STROBE_N(rd_n), .ADDR_LATCH_STROBE_N(als_n),
        .ADDR(addr), .BYTE_LANE_EN_N(be_n), .CHIP_SLEEP_N(sleep_n),
        .CFG_ROM_PRESENT_STRAP(strap), .CFG_ROM_SERIAL_IN(rom_in),
        .CFG_ROM_SERIAL_OUT(rom_out), .CFG_ROM_SERIAL_CLK(rom_sk),
        .CFG_ROM_SELECT(rom_cs), .LOCAL_SELECT_N(lsel_n),
        .ACCESS_WRITE(acc_wr), .ACCESS_READ(acc_rd),
        .ACCESS_ADDR(acc_addr), .ACCESS_BE(acc_be), .BUS_WIDTH(bus_w),
        .CFG_DONE(cfg_done), .SLEEP_STATE(asleep));
    hbc_rom_model #(.WORDS(WORDS), .W0(W0)) hbc_rom_model_inst (.sk(rom_sk),
        .cs(rom_cs), .di(rom_out), .dout(rom_do), .cmd_err(cmd_err));
    task automatic print_verdict;
        if (fail_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e)
        begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask
    // One Avalon transfer, held until waitrequest is sampled low
    task automatic av(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [3:0] b);
        int n;
        @(posedge core_clk);
        av_addr <= a;
        av_wdata <= d;
        av_be <= b;
        av_wr <= w;
        av_rd <= !w;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (av_wait !== 1'b0 && n < 50);
        rd = av_rdata;
        av_wr <= 1'b0;
        av_rd <= 1'b0;
        if (n >= 50)
            chk("waitrequest", 32'h0, 32'h1);
    endtask
    task automatic pins(input logic q, input logic [15:1] a,
        input logic w, r, s, input logic [3:0] b);
        @(posedge core_clk);
        qual_n <= q;
        addr <= a;
        wr_n <= w;
        rd_n <= r;
        sync_write_read_sel <= s;
        be_n <= b;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    task automatic do_reset(input logic s, input logic d);
        @(posedge core_clk);
        rstn <= 1'b0;
        strap <= s;
        din_lvl <= d;
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (4) @(negedge core_clk);
    endtask
    task automatic wait_sk(input logic lvl, output int n);
        n = 0;
        while (rom_sk !== lvl && n < 400)
        begin
            @(posedge core_clk);
            n++;
        end
    endtask
    task automatic t_width;
        for (int v = 0; v < 2; v++)
        begin
            do_reset(1'b0, v[0]);
            chk("bus_width", 32'(v), 32'(bus_w));
            chk("rom_select", 32'h0, 32'(rom_cs));
            av(1'b0, 8'h04, 32'h0, 4'hF);
            chk("status_width", 32'(v), 32'(rd[4:3]));
        end
        av(1'b0, 8'h08, 32'h0, 4'hF);
        chk("base_reset", 32'h0300, rd);
        av(1'b0, 8'hFC, 32'h0, 4'hF);
        chk("unmapped_read", 32'h0, rd);
        av(1'b1, 8'h00, 32'h4, 4'h1);
        repeat (3) @(negedge core_clk);
        chk("force32", 32'h2, 32'(bus_w));
    endtask
    task automatic t_claim;
        av(1'b1, 8'h00, 32'h0, 4'h1);
        pins(1'b0, 15'h0180, 1'b0, 1'b1, 1'b0, 4'hA);
        chk("local_select_n", 32'h0, 32'(lsel_n));
        chk("access_write", 32'h1, 32'(acc_wr));
        chk("access_be", 32'h5, 32'(acc_be));
        chk("access_addr", 32'h0180, 32'(acc_addr));
        pins(1'b0, 15'h0181, 1'b1, 1'b0, 1'b0, 4'h0);
        chk("access_read", 32'h1, 32'(acc_rd));
        chk("access_write", 32'h0, 32'(acc_wr));
        pins(1'b1, 15'h0181, 1'b1, 1'b0, 1'b0, 4'h0);
        chk("local_select_n", 32'h1, 32'(lsel_n));
        chk("access_be", 32'h0, 32'(acc_be));
        pins(1'b0, 15'h0188, 1'b1, 1'b0, 1'b0, 4'h0);
        chk("local_select_n", 32'h1, 32'(lsel_n));
        av(1'b1, 8'h00, 32'h1, 4'h1);
        pins(1'b0, 15'h0180, 1'b1, 1'b1, 1'b1, 4'h0);
        chk("sync_write", 32'h1, 32'(acc_wr));
        pins(1'b0, 15'h0180, 1'b1, 1'b1, 1'b0, 4'h0);
        chk("sync_read", 32'h1, 32'(acc_rd));
        av(1'b1, 8'h08, 32'h1230, 4'h3);
        pins(1'b0, 15'h091A, 1'b1, 1'b1, 1'b0, 4'h0);
        chk("local_select_n", 32'h0, 32'(lsel_n));
        av(1'b1, 8'h08, 32'h0300, 4'h3);
    endtask
    task automatic t_latch;
        av(1'b1, 8'h00, 32'h2, 4'h1);
        @(posedge core_clk);
        als_n <= 1'b0;
        pins(1'b0, 15'h0180, 1'b1, 1'b1, 1'b0, 4'h0);
        @(posedge core_clk);
        als_n <= 1'b1;
        pins(1'b1, 15'h0400, 1'b1, 1'b1, 1'b0, 4'h0);
        chk("latched_select", 32'h0, 32'(lsel_n));
        chk("latched_addr", 32'h0180, 32'(acc_addr));
        av(1'b0, 8'h0C, 32'h0, 4'hF);
        chk("latch_reg", 32'h0180, 32'(rd[15:1]));
        @(posedge core_clk);
        als_n <= 1'b0;
        @(posedge core_clk);
        als_n <= 1'b1;
        repeat (3) @(negedge core_clk);
        chk("relatched_select", 32'h1, 32'(lsel_n));
        av(0, 8'h04, 32'h0, 4'hF);
        chk("latched_qual", 32'h1, 32'(rd[6]));
        av(1'b1, 8'h00, 32'h0, 4'h1);
    endtask
    task automatic t_sleep;
        pins(1'b0, 15'h0180, 1'b0, 1'b1, 1'b0, 4'h0);
        @(posedge core_clk);
        sleep_n <= 1'b0;
        repeat (3) @(negedge core_clk);
        chk("asleep", 32'h1, 32'(asleep));
        chk("sleep_select", 32'h1, 32'(lsel_n));
        @(posedge core_clk);
        sleep_n <= 1'b1;
        repeat (3) @(negedge core_clk);
        chk("awake", 32'h0, 32'(asleep));
        chk("awake_select", 32'h0, 32'(lsel_n));
        pins(1'b1, 15'h0, 1'b1, 1'b1, 1'b0, 4'hF);
    endtask
    task automatic t_rom;
        int k1;
        int k2;
        do_reset(1'b1, 1'b0);
        wait_sk(1'b1, k1);
        wait_sk(1'b0, k1);
        wait_sk(1'b1, k2);
        chk("sk_period", 32'd160, 32'(k1 + k2));
        k1 = 0;
        while (cfg_done !== 1'b1 && k1 < 30000)
        begin
            @(posedge core_clk);
            k1++;
        end
        @(negedge core_clk);
        chk("cfg_done", 32'h1, 32'(cfg_done));
        chk("rom_command", 32'h0, 32'(cmd_err));
        chk("rom_select", 32'h0, 32'(rom_cs));
        chk("rom_width", 32'h1, 32'(bus_w));
        for (int i = 0; i < WORDS; i++)
        begin
            av(1'b0, 8'(16 + 4 * i), 32'h0, 4'hF);
            chk("cfg_word", (i == 0) ? W0 : 32'hC3A0 + i, rd);
        end
        av(1'b1, 8'h00, 32'h8, 4'h1);
        av(1'b0, 8'h04, 32'h0, 4'hF);
        chk("reload_busy", 32'h1, 32'(rd[1]));
    endtask
    initial
    begin
        t_width;
        t_claim;
        t_latch;
        t_sleep;
        t_rom;
        print_verdict;
    end
    initial
    begin
        repeat (80000) @(posedge core_clk);
        fail_count++;
        print_verdict;
    end
endmodule
